// [inc/asc_pkg.sv]
// Shared constants for the converter sequencer control block.
// Assumes an 8-bit CPU register space and a separate control-register space.
package asc_pkg;

  // Register addresses (data space and control space share numbers)
  localparam logic [3:0] ASC_CTRL_ADDR   = 4'h9;
  localparam logic [3:0] ASC_RESULT_ADDR = 4'hA;
  localparam logic [3:0] ASC_GAIN_ADDR   = 4'h9;
  localparam logic [3:0] ASC_CFG_ADDR    = 4'hA;

  // Reset values
  localparam logic [7:0] ASC_CTRL_RST   = 8'h00;
  localparam logic [7:0] ASC_CFG_RST    = 8'h00;
  localparam logic [7:0] ASC_GAIN_RST   = 8'h00;
  localparam logic [7:0] ASC_RESULT_RST = 8'h00;

  // Converter control fields
  localparam int ASC_PORTSEL_BIT = 5;
  localparam int ASC_RUN_BIT     = 4;
  localparam int ASC_PWR_BIT     = 3;
  localparam int ASC_CHAN_LSB    = 0;

  // Converter configuration fields
  localparam int ASC_REFSEL_BIT  = 7;
  localparam int ASC_CMPEN_BIT   = 6;
  localparam int ASC_CMPOUT_BIT  = 5;
  localparam int ASC_PORTCFG_LSB = 2;
  localparam int ASC_CLKSEL_LSB  = 0;

  // Amplifier gain control fields
  localparam int ASC_AMP2EN_BIT = 7;
  localparam int ASC_AMP1EN_BIT = 6;
  localparam int ASC_GAIN2_LSB  = 3;
  localparam int ASC_GAIN1_LSB  = 0;

  // Conversion clock choices and dividers
  localparam logic [1:0] ASC_CLK_DIV4  = 2'h0;
  localparam logic [1:0] ASC_CLK_DIV16 = 2'h1;
  localparam logic [1:0] ASC_CLK_DIV64 = 2'h2;
  localparam logic [1:0] ASC_CLK_RC    = 2'h3;
  localparam int         ASC_DIV_A     = 4;
  localparam int         ASC_DIV_B     = 16;
  localparam int         ASC_DIV_C     = 64;

  // Result width
  localparam int ASC_RES_BITS = 8;

  // Sequencer states
  typedef enum logic [1:0] {
    ASC_IDLE = 2'b01,
    ASC_CONV = 2'b10
  } asc_state_e;

endpackage

// [inc/asc_tick_if.sv]
// Carrier between the sequencer and its conversion clock generator.
// Both ends sit on the same system clock.
`timescale 1ns/10ps
interface asc_tick_if;
  logic [1:0] sel;
  logic       en;
  logic       tick;
  modport ctrl (output sel, output en, input tick);
  modport gen  (input sel, input en, output tick);
endinterface

// [hw/asc_conv_clk.sv]
// Conversion clock generator: one tick per bit period.
// Assumes the ring oscillator arrives as a one-cycle strobe on the system clock.
`timescale 1ns/10ps
module asc_conv_clk
  import asc_pkg::*;
#(
  parameter int DIV_A = ASC_DIV_A,
  parameter int DIV_B = ASC_DIV_B,
  parameter int DIV_C = ASC_DIV_C
) (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rstn_i,
  // Ring oscillator strobe
  input  wire logic rc_tick_i,
  // Sequencer side
  asc_tick_if.gen   tk
);

  logic [6:0] cnt;
  logic [6:0] lim;

  // Terminal count for the selected divider
  always_comb begin
    if (tk.sel == ASC_CLK_DIV4) begin
      lim = 7'(DIV_A - 1);
    end else if (tk.sel == ASC_CLK_DIV16) begin
      lim = 7'(DIV_B - 1);
    end else begin
      lim = 7'(DIV_C - 1);
    end
  end

  // Restarts from zero whenever disabled, so every period is whole
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt <= 7'h00;
    end else if (!tk.en || cnt == lim) begin
      cnt <= 7'h00;
    end else begin
      cnt <= cnt + 7'h01;
    end
  end

  // Tick source
  assign tk.tick = tk.en && ((tk.sel == ASC_CLK_RC) ? rc_tick_i : (cnt == lim));

endmodule

// [hw/asc_seq_ctrl.sv]
// Sequencer control for an 8-bit successive-approximation converter.
// Assumes the CPU reaches registers with one-cycle write and read strobes;
// the analog array returns the comparator decision for the current trial code.
`timescale 1ns/10ps
// What this block does
// - Control register: port select, run, power, channel
// - Writing one to run starts conversion
// - Run cleared only by hardware on finish
// - Power bit zero switches reference ladder off
// - Channel code n routes input n
// - Channel changes only while done and run low
// - Configuration register: reference, comparator, port, clock
// - Reference from supply or from reference pin
// - Comparator enable, pin route or amplifier mode
// - Clock select: divide 4, 16, 64, ring
// - Gain register: two enables, two gain codes
// - Gain codes select gains 1 to 32
// - Completion loads result, clears run, sets done
// - In sleep only ring-clocked conversion continues
// - Sleep completion with mask set wakes device
// - Sleep with mask clear shuts converter off
// - Bits resolved most significant first
// - Done always set; request is flag AND mask
module asc_seq_ctrl
  import asc_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rstn_i,
  // CPU register access
  input  wire logic [3:0] reg_addr_i,
  input  wire logic [7:0] reg_wdata_i,
  input  wire logic       reg_we_i,
  input  wire logic       reg_re_i,
  input  wire logic       ioc_we_i,
  input  wire logic       ioc_re_i,
  output logic      [7:0] rdata_o,
  // Interrupt flag, mask and sleep
  input  wire logic       irq_mask_i,
  input  wire logic       done_clr_i,
  input  wire logic       sleep_i,
  output logic            done_flag_o,
  output logic            irq_o,
  output logic            wake_o,
  // Ring oscillator strobe
  input  wire logic       rc_tick_i,
  // Analog array
  input  wire logic       cmp_result_i,
  output logic      [7:0] sar_code_o,
  output logic      [2:0] channel_o,
  output logic            ladder_on_o,
  output logic            converting_o,
  // Reference, comparator and port
  output logic            ref_ext_o,
  output logic            comparator_en_o,
  output logic            comparator_pin_o,
  output logic            opamp_mode_o,
  output logic      [2:0] port_cfg_o,
  output logic            port_space_o,
  // Gain amplifiers
  output logic            amp1_en_o,
  output logic            amp2_en_o,
  output logic      [2:0] amp1_gain_o,
  output logic      [2:0] amp2_gain_o,
  output logic      [2:0] amp1_shift_o,
  output logic      [2:0] amp2_shift_o
);

  // Gain code to power-of-two exponent; unused codes saturate at 32
  function automatic logic [2:0] gain_exp(input logic [2:0] code);
    gain_exp = (code > 3'h5) ? 3'h5 : code;
  endfunction

  // One-hot mask for a result bit position
  function automatic logic [7:0] bit_mask(input logic [2:0] idx);
    bit_mask = 8'h01 << idx;
  endfunction

  asc_tick_if tk ();

  asc_state_e state;
  asc_state_e next_state;
  logic [5:0] ctrl_q;
  logic [7:0] cfg_q;
  logic [7:0] gain_q;
  logic [7:0] result_q;
  logic [7:0] sar_q;
  logic [2:0] bit_idx;
  logic [7:0] next_sar;
  logic       start_req;
  logic       done_evt;
  logic       shut_off;
  logic       run;
  logic       ctrl_we;

  // Address decode
  assign ctrl_we   = reg_we_i && reg_addr_i == ASC_CTRL_ADDR;
  assign start_req = ctrl_we && reg_wdata_i[ASC_RUN_BIT];
  assign run       = (state == ASC_CONV);
  assign done_evt  = run && tk.tick && bit_idx == 3'h0;
  assign shut_off  = sleep_i && !irq_mask_i;

  // Control register; run is the sequencer state, so software zero is ignored
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ctrl_q <= ASC_CTRL_RST[5:0];
    end else if (ctrl_we) begin
      ctrl_q <= reg_wdata_i[5:0];
    end
  end

  // Configuration and gain registers in the control space
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cfg_q  <= ASC_CFG_RST;
      gain_q <= ASC_GAIN_RST;
    end else if (ioc_we_i) begin
      if (reg_addr_i == ASC_CFG_ADDR) begin
        cfg_q <= reg_wdata_i;
      end else if (reg_addr_i == ASC_GAIN_ADDR) begin
        gain_q <= reg_wdata_i;
      end
    end
  end

  // Sequencer: a start while already running is absorbed
  always_comb begin
    next_state = state;
    case (state)
      ASC_IDLE: begin
        if (start_req) begin
          next_state = ASC_CONV;
        end
      end
      ASC_CONV: begin
        if (done_evt) begin
          next_state = ASC_IDLE;
        end
      end
      default: begin
        next_state = ASC_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state <= ASC_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Bit periods only while powered and not frozen by sleep
  assign tk.sel = cfg_q[ASC_CLKSEL_LSB +: 2];
  assign tk.en  = run && ctrl_q[ASC_PWR_BIT] && !shut_off
                  && (!sleep_i || tk.sel == ASC_CLK_RC);

  // Trial update: keep or drop the bit under test, then try the next one down
  always_comb begin
    next_sar = cmp_result_i ? sar_q : (sar_q & ~bit_mask(bit_idx));
    if (bit_idx != 3'h0) begin
      next_sar = next_sar | bit_mask(bit_idx - 3'h1);
    end
  end

  // Approximation register and bit index
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sar_q   <= 8'h00;
      bit_idx <= 3'h0;
    end else if (state == ASC_IDLE && start_req) begin
      sar_q   <= bit_mask(3'h7);
      bit_idx <= 3'h7;
    end else if (run && tk.tick) begin
      sar_q   <= next_sar;
      bit_idx <= bit_idx - 3'h1;
    end
  end

  // Result loads only on completion
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      result_q <= ASC_RESULT_RST;
    end else if (done_evt) begin
      result_q <= next_sar;
    end
  end

  // Done flag: hardware set wins over a clear in the same cycle
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      done_flag_o <= 1'b0;
    end else if (done_evt) begin
      done_flag_o <= 1'b1;
    end else if (done_clr_i) begin
      done_flag_o <= 1'b0;
    end
  end

  // Wake pulse after a sleeping conversion finishes
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wake_o <= 1'b0;
    end else begin
      wake_o <= done_evt && sleep_i && irq_mask_i;
    end
  end

  // Channel switches only between conversions, to avoid corrupting a sample
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      channel_o <= 3'h0;
    end else if (!run && !done_flag_o) begin
      channel_o <= ctrl_q[ASC_CHAN_LSB +: 3];
    end
  end

  // Registered read port; unknown addresses read zero
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdata_o <= 8'h00;
    end else if (reg_re_i) begin
      if (reg_addr_i == ASC_CTRL_ADDR) begin
        rdata_o <= {2'b00, ctrl_q[5], run, ctrl_q[3:0]};
      end else if (reg_addr_i == ASC_RESULT_ADDR) begin
        rdata_o <= result_q;
      end else begin
        rdata_o <= 8'h00;
      end
    end else if (ioc_re_i) begin
      if (reg_addr_i == ASC_CFG_ADDR) begin
        rdata_o <= cfg_q;
      end else if (reg_addr_i == ASC_GAIN_ADDR) begin
        rdata_o <= gain_q;
      end else begin
        rdata_o <= 8'h00;
      end
    end
  end

  // Request and analog control outputs
  assign irq_o            = done_flag_o && irq_mask_i;
  assign sar_code_o       = sar_q;
  assign converting_o     = run;
  assign ladder_on_o      = ctrl_q[ASC_PWR_BIT] && !shut_off;
  assign ref_ext_o        = cfg_q[ASC_REFSEL_BIT];
  assign comparator_en_o  = cfg_q[ASC_CMPEN_BIT];
  assign comparator_pin_o = cfg_q[ASC_CMPEN_BIT] && cfg_q[ASC_CMPOUT_BIT];
  assign opamp_mode_o     = cfg_q[ASC_CMPEN_BIT] && !cfg_q[ASC_CMPOUT_BIT];
  assign port_cfg_o       = cfg_q[ASC_PORTCFG_LSB +: 3];
  assign port_space_o     = ctrl_q[ASC_PORTSEL_BIT];
  assign amp1_en_o        = gain_q[ASC_AMP1EN_BIT];
  assign amp2_en_o        = gain_q[ASC_AMP2EN_BIT];
  assign amp1_gain_o      = gain_q[ASC_GAIN1_LSB +: 3];
  assign amp2_gain_o      = gain_q[ASC_GAIN2_LSB +: 3];
  assign amp1_shift_o     = gain_exp(gain_q[ASC_GAIN1_LSB +: 3]);
  assign amp2_shift_o     = gain_exp(gain_q[ASC_GAIN2_LSB +: 3]);

  asc_conv_clk u_conv_clk (
    .clk_i     (clk_i),
    .rstn_i    (rstn_i),
    .rc_tick_i (rc_tick_i),
    .tk        (tk.gen)
  );

  // Helper: ticks seen in the current conversion
  logic [3:0] tick_seen;
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tick_seen <= 4'h0;
    end else if (state == ASC_IDLE) begin
      tick_seen <= 4'h0;
    end else if (tk.tick) begin
      tick_seen <= tick_seen + 4'h1;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  a_run_start_set: assert property (state == ASC_IDLE && start_req |=> run && sar_code_o == 8'h80)
    else $error("run did not start on write of one");
  a_run_hw_clear: assert property (run && !done_evt |=> run)
    else $error("run dropped without completion");
  a_done_loads: assert property (done_evt |=> !run && done_flag_o
                                 && (rdata_o == $past(rdata_o) || $past(reg_re_i || ioc_re_i)))
    else $error("completion effects missing");
  a_result_value: assert property (done_evt |=> result_q == $past(next_sar))
    else $error("result not loaded on completion");
  a_eight_ticks: assert property (done_evt |-> tick_seen == 4'h7)
    else $error("conversion not eight bit periods");
  a_chan_hold: assert property ((run || done_flag_o) |=> $stable(channel_o))
    else $error("channel changed during conversion");
  a_chan_follow: assert property (!run && !done_flag_o |=> channel_o == $past(ctrl_q[2:0]))
    else $error("channel did not follow select");
  a_ladder_off: assert property (!ctrl_q[ASC_PWR_BIT] || shut_off |-> !ladder_on_o && !tk.tick)
    else $error("ladder on while powered down");
  a_sleep_freeze: assert property (sleep_i && tk.sel != ASC_CLK_RC && run |=> $stable(sar_q))
    else $error("conversion ran in sleep without ring clock");
  a_wake_pulse: assert property (done_evt && sleep_i && irq_mask_i |=> wake_o ##1 !wake_o || done_evt)
    else $error("no wake after sleeping completion");
  a_irq_follow: assert property (done_evt && irq_mask_i |=> irq_o)
    else $error("request missing after completion");

endmodule

// [verif/asc_analog_model.sv]
// Behavioural analog array: eight input levels and one comparator.
// Assumes the sequencer keeps the trial bit when the comparator answers one.
`timescale 1ns/10ps
module asc_analog_model (
  // Sequencer side
  input  wire logic [7:0]  sar_code_i,
  input  wire logic [2:0]  channel_i,
  input  wire logic        ladder_on_i,
  // Test levels, one byte per input
  input  wire logic [63:0] levels_i,
  // Decision
  output logic             cmp_o
);
  // No ladder, no reference: answer is noise, so a stalled run cannot pass by luck
  assign cmp_o = ladder_on_i ? (sar_code_i <= levels_i[channel_i*8 +: 8]) : sar_code_i[0];
endmodule

// [verif/asc_seq_ctrl_tb.sv]
// Self-checking bench for the converter sequencer control block.
// Assumes the analog model on the far side and a 50 MHz system clock.
`timescale 1ns/10ps
module asc_seq_ctrl_tb;
  import asc_pkg::*;
  localparam int DLY = 2;
  logic        clk_i, rstn_i, reg_we_i, reg_re_i, ioc_we_i, ioc_re_i;
  logic        irq_mask_i, done_clr_i, sleep_i, cmp_result_i;
  logic        rc_tick_i = 1'b0;
  logic [3:0]  reg_addr_i;
  logic [7:0]  reg_wdata_i, rdata_o, sar_code_o, seed;
  logic [2:0]  channel_o, port_cfg_o, amp1_gain_o, amp2_gain_o, amp1_shift_o, amp2_shift_o;
  logic        done_flag_o, irq_o, wake_o, ladder_on_o, converting_o, ref_ext_o;
  logic        comparator_en_o, comparator_pin_o, opamp_mode_o, port_space_o, amp1_en_o, amp2_en_o;
  logic [63:0] levels;
  logic [7:0]  expq[$];
  int          mismatches, checked, cyc, wake_n, rc_cnt;

  asc_seq_ctrl uut (.*);
  asc_analog_model model (.sar_code_i(sar_code_o), .channel_i(channel_o), .ladder_on_i(ladder_on_o),
                          .levels_i(levels), .cmp_o(cmp_result_i));

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  function automatic logic [2:0] shf(input logic [2:0] c);
    return (c > 3'd5) ? 3'd5 : c;
  endfunction

  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("mismatches %0d checked %0d", mismatches, checked);
    if (mismatches == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // One register access; ctl picks the control space
  task automatic acc(input logic ctl, input logic wr, input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_i);
    #DLY;
    reg_addr_i = a;
    reg_wdata_i = d;
    reg_we_i = wr & ~ctl;
    ioc_we_i = wr & ctl;
    reg_re_i = ~wr & ~ctl;
    ioc_re_i = ~wr & ctl;
    @(posedge clk_i);
    #DLY;
    {reg_we_i, ioc_we_i, reg_re_i, ioc_re_i} = 4'h0;
  endtask
  // Read: note expectation, let the monitor compare
  task automatic rd(input logic ctl, input logic [3:0] a, input logic [7:0] e);
    expq.push_back(e);
    acc(ctl, 1'b0, a, 8'h00);
    @(posedge clk_i);
    #DLY;
  endtask
  task automatic clr();
    done_clr_i = 1'b1;
    @(posedge clk_i);
    #DLY;
    done_clr_i = 1'b0;
  endtask
  task automatic waitc(input int n);
    repeat (n) @(posedge clk_i);
    #DLY;
  endtask
  // Rest after the last run, pick the channel, let the input settle, then set run;
  // the channel only moves while idle, so a combined write would convert the old one
  task automatic start(input logic [7:0] c);
    waitc(130);
    acc(1'b0, 1'b1, ASC_CTRL_ADDR, c & 8'hEF);
    waitc(50);
    acc(1'b0, 1'b1, ASC_CTRL_ADDR, c);
  endtask
  // Wait for completion; the bit count bounds the duration
  task automatic finish(input logic [2:0] ch, input int lo, input int hi);
    int n;
    n = 0;
    while (done_flag_o !== 1'b1 && n < hi) begin
      @(posedge clk_i);
      #DLY;
      n++;
    end
    cmp({7'd0, n >= lo && n < hi}, 8'h01);
    cmp({7'd0, converting_o}, 8'h00);
    cmp({5'd0, channel_o}, {5'd0, ch});
    rd(1'b0, ASC_RESULT_ADDR, levels[ch*8 +: 8]);
    rd(1'b0, ASC_CTRL_ADDR, 8'h08 | ch);
  endtask

  // Read data appears the cycle after the strobe edge
  initial forever begin
    @(posedge clk_i);
    if (reg_re_i === 1'b1 || ioc_re_i === 1'b1) begin
      @(posedge clk_i);
      #1;
      cmp(rdata_o, expq.pop_front());
    end
  end
  // Ring oscillator strobe every fifth cycle, free running
  always @(posedge clk_i) begin
    rc_cnt <= (rc_cnt == 4) ? 0 : rc_cnt + 1;
    rc_tick_i <= #DLY (rc_cnt == 0);
    if (wake_o === 1'b1) wake_n <= wake_n + 1;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      mismatches++;
      report_and_stop();
    end
  end
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  initial begin
    logic [7:0] v;
    {reg_we_i, ioc_we_i, reg_re_i, ioc_re_i, irq_mask_i, done_clr_i, sleep_i} = 7'h00;
    {rstn_i, reg_addr_i, reg_wdata_i, mismatches, checked, cyc, wake_n, rc_cnt} = '0;
    seed = 8'd57;
    for (int i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      levels[i*8 +: 8] = seed;
    end
    waitc(16);
    rstn_i = 1'b1;
    // Reset values and unmapped place
    rd(1'b0, ASC_CTRL_ADDR, ASC_CTRL_RST);
    rd(1'b1, ASC_CFG_ADDR, ASC_CFG_RST);
    rd(1'b1, ASC_GAIN_ADDR, ASC_GAIN_RST);
    rd(1'b0, 4'h3, 8'h00);
    acc(1'b0, 1'b1, ASC_CTRL_ADDR, 8'hE9);
    rd(1'b0, ASC_CTRL_ADDR, 8'h29);
    cmp({7'd0, port_space_o}, 8'h01);
    // Configuration fields with random values
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      v = seed;
      acc(1'b1, 1'b1, ASC_CFG_ADDR, v);
      rd(1'b1, ASC_CFG_ADDR, v);
      cmp({ref_ext_o, comparator_en_o, comparator_pin_o, opamp_mode_o, port_cfg_o, 1'b0},
          {v[7], v[6], v[6] & v[5], v[6] & ~v[5], v[4:2], 1'b0});
    end
    // Every gain code on both amplifiers
    for (int g = 0; g < 8; g++) begin
      v = {g[0], ~g[0], g[2:0], 3'(7 - g)};
      acc(1'b1, 1'b1, ASC_GAIN_ADDR, v);
      rd(1'b1, ASC_GAIN_ADDR, v);
      cmp({amp2_en_o, amp1_en_o, amp2_gain_o, amp1_gain_o}, v);
      cmp({2'd0, amp2_shift_o, amp1_shift_o}, {2'd0, shf(v[5:3]), shf(v[2:0])});
    end
    // One conversion per divided clock
    for (int d = 0; d < 3; d++) begin
      acc(1'b1, 1'b1, ASC_CFG_ADDR, {6'd0, 2'(d)});
      clr();
      start(8'h18 | 3'(d * 3));
      finish(3'(d * 3), 8 * (4 << (2 * d)) - 4, 8 * (4 << (2 * d)) + 3);
    end
    // Done set with mask low; request follows mask
    cmp({6'd0, done_flag_o, irq_o}, 8'h02);
    irq_mask_i = 1'b1;
    #1;
    cmp({6'd0, done_flag_o, irq_o}, 8'h03);
    // Channel held while done flag high, then follows
    acc(1'b0, 1'b1, ASC_CTRL_ADDR, 8'h09);
    cmp({5'd0, channel_o}, 8'h06);
    clr();
    acc(1'b0, 1'b1, ASC_CTRL_ADDR, 8'h09);
    waitc(1);
    cmp({5'd0, channel_o}, 8'h01);
    // Run without power stalls; zero to run and new channel ignored
    acc(1'b1, 1'b1, ASC_CFG_ADDR, {6'd0, ASC_CLK_DIV4});
    start(8'h12);
    acc(1'b0, 1'b1, ASC_CTRL_ADDR, 8'h05);
    waitc(60);
    cmp({6'd0, converting_o, ladder_on_o}, 8'h02);
    cmp({5'd0, channel_o}, 8'h02);
    acc(1'b0, 1'b1, ASC_CTRL_ADDR, 8'h1A);
    finish(3'd2, 20, 40);
    // Sleep with divided clock freezes the run
    clr();
    sleep_i = 1'b1;
    start(8'h1C);
    waitc(100);
    cmp({7'd0, converting_o}, 8'h01);
    sleep_i = 1'b0;
    finish(3'd4, 20, 40);
    // Sleep on the ring clock completes and wakes
    acc(1'b1, 1'b1, ASC_CFG_ADDR, {6'd0, ASC_CLK_RC});
    clr();
    sleep_i = 1'b1;
    start(8'h1F);
    finish(3'd7, 30, 50);
    cmp(8'(wake_n), 8'h01);
    // Sleep with mask low shuts the converter off
    irq_mask_i = 1'b0;
    #1;
    cmp({7'd0, ladder_on_o}, 8'h00);
    sleep_i = 1'b0;
    waitc(4);
    report_and_stop();
  end
endmodule
